// *** hdl/serial_port_map.svh ***
`ifndef SERIAL_PORT_MAP_SVH
`define SERIAL_PORT_MAP_SVH

// register byte addresses
`define SP_ADDR_DATA        12'h09a
`define SP_ADDR_AUX1        12'h0a2
`define SP_ADDR_CTRL        12'h0c0
`define SP_ADDR_MISC        12'h0c8
`define SP_ADDR_STATUS      12'h0cc

// control register field positions
`define SP_CTRL_RXDONE      0
`define SP_CTRL_TXDONE      1
`define SP_CTRL_RXNINTH     2
`define SP_CTRL_TXNINTH     3
`define SP_CTRL_RXEN        4
`define SP_CTRL_QUAL        5
`define SP_CTRL_MLO         6
`define SP_CTRL_MHI         7

// aux register fields
`define SP_AUX1_SWAP        2
`define SP_AUX1_RO_ZERO     1
`define SP_AUX1_RESET       8'h00

// misc register fields
`define SP_MISC_DOUBLE      0
`define SP_MISC_ADDR_LO     8
`define SP_MISC_ADDR_HI     15

// reset values
`define SP_DATA_RESET       8'h00
`define SP_CTRL_RESET       8'h00
`define SP_ADDR_RESET       8'h00

// fixed dividers
`define SP_DIV_M0_SLOW      6'd12
`define SP_DIV_M0_FAST      6'd2
`define SP_DIV_M2_SLOW      7'd64
`define SP_DIV_M2_FAST      7'd32
// timer overflow rate is divided by 32, or by 16 when doubled
`define SP_OVF_SLOW         5'd31
`define SP_OVF_FAST         5'd15
// sixteen oversample ticks per asynchronous bit
`define SP_OVS_LAST         4'd15
`define SP_OVS_MID          4'd7

// frame bit counts
`define SP_BITS_M0          4'd8
`define SP_BITS_M1          4'd9
`define SP_BITS_M23         4'd10

`endif

// *** hdl/serial_port_pkg.sv ***
`default_nettype none
package serial_port_pkg;
    // operating modes, one-hot
    typedef enum logic [3:0] {
        MODE_SYNC   = 4'b0001,
        MODE_ASYNC8 = 4'b0010,
        MODE_FIX9   = 4'b0100,
        MODE_TMR9   = 4'b1000
    } op_mode_e;
    // transmit states
    typedef enum logic [2:0] {
        TX_IDLE  = 3'b001,
        TX_SHIFT = 3'b010,
        TX_DONE  = 3'b100
    } tx_state_e;
    // receive states
    typedef enum logic [2:0] {
        RX_IDLE  = 3'b001,
        RX_SHIFT = 3'b010,
        RX_END   = 3'b100
    } rx_state_e;
endpackage
`default_nettype wire

// *** hdl/serial_port_four_mode_uart.sv ***
// Operation
// - mode 0: data on rx pin, clock on tx
// - mode 0 clock: sysclk/12, or /2 when qualified
// - mode 0: device always drives shift clock
// - lsb first; mode 0 rate equals shift clock
// - mode 0: buffer write sends 8 bits, txdone
// - mode 0: rxen and not rxdone receives byte
// - mode 1 frame: start, 8 data, stop
// - mode 1 rate from timer overflow, doubled
// - mode 1 transmit; txdone once stop appears
// - async receive starts on falling edge
// - mode 1 conditional load at mid stop
// - after frame, rearm for next falling edge
// - mode 2 frame: start, 8, ninth, stop
// - mode 2 rate sysclk/32 or /64
// - mode 2 transmit sends ninth bit field
// - mode 2 conditional load with ninth bit
// - mode 3 like mode 2, timer rate
// - data buffer: write tx, read rx
// - pin swap bit exchanges pins immediately
// - two mode bits select modes 0 to 3
// - only software clears the done flags
//
// Added by the designer: the APB interface to the registers.
`include "serial_port_map.svh"
`default_nettype none
module serial_port_four_mode_uart (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // baud source: one-cycle timer overflow pulse
    input  wire logic        i_timer_ovf,
    // serial pins, each as in/out/enable (enable low drives)
    input  wire logic        i_pin_a,
    output logic             o_pin_a,
    output logic             o_pin_a_oen,
    input  wire logic        i_pin_b,
    output logic             o_pin_b,
    output logic             o_pin_b_oen
);
    // software registers
    logic [7:0]  ctrl_q;        // mode, qualifier, rxen, ninth bits, flags
    logic [7:0]  rxbuf_q;       // receive register, read side of buffer
    logic [7:0]  aux_q;         // auxiliary control one
    logic        dbl_q;         // baud double
    logic [7:0]  addr_q;        // station address for qualified receive
    // engine state
    serial_port_pkg::tx_state_e tx_st_q;
    serial_port_pkg::rx_state_e rx_st_q;
    logic [9:0]  tx_sh_q;       // outgoing frame, lsb first
    logic [3:0]  tx_cnt_q;      // bits left in frame
    logic [3:0]  tx_ovs_q;      // oversample count for tx bit
    logic [9:0]  rx_sh_q;       // incoming bits, shift in at top
    logic [3:0]  rx_cnt_q;      // bits taken
    logic [3:0]  rx_ovs_q;      // oversample phase
    logic        rxd_q;         // last rx line sample, edge finder
    logic        sclk_q;        // mode 0 shift clock level
    logic [5:0]  div0_q;        // mode 0 divider
    logic [6:0]  div2_q;        // mode 2 divider
    logic [4:0]  ovf_q;         // timer overflow prescaler
    // pin output registers
    logic        pa_q, pa_oen_q, pb_q, pb_oen_q;

    // mode decode, high bit then low bit
    wire  [1:0]  mode_bits = {ctrl_q[`SP_CTRL_MHI], ctrl_q[`SP_CTRL_MLO]};
    wire         m0   = (mode_bits == 2'b00);
    wire         m1   = (mode_bits == 2'b01);
    wire         m9   = mode_bits[1];
    wire         qual = ctrl_q[`SP_CTRL_QUAL];
    wire         rxen = ctrl_q[`SP_CTRL_RXEN];
    wire         rxdn = ctrl_q[`SP_CTRL_RXDONE];
    wire         swap = aux_q[`SP_AUX1_SWAP];

    // apb decode; slave answers one edge into the access phase, one wait state
    wire         acc     = i_psel & i_penable;
    wire         wr      = acc & i_pwrite;
    wire         hit_dat = (i_paddr == `SP_ADDR_DATA);
    wire         hit_aux = (i_paddr == `SP_ADDR_AUX1);
    wire         hit_ctl = (i_paddr == `SP_ADDR_CTRL);
    wire         hit_msc = (i_paddr == `SP_ADDR_MISC);
    wire         hit_sts = (i_paddr == `SP_ADDR_STATUS);
    wire         hit_any = hit_dat | hit_aux | hit_ctl | hit_msc | hit_sts;
    wire         wr_dat  = wr & hit_dat;
    wire         wr_ctl  = wr & hit_ctl;
    wire  [7:0]  wd      = i_pwdata[7:0];

    // mode 0 rate: each divider wrap is one half of a shift clock
    wire  [5:0]  div0_end = qual ? (`SP_DIV_M0_FAST >> 1) - 6'd1
                                 : (`SP_DIV_M0_SLOW >> 1) - 6'd1;
    wire         half0    = (div0_q >= div0_end);
    // mode 2 oversample tick: bit time /16
    wire  [6:0]  div2_end = dbl_q ? (`SP_DIV_M2_FAST >> 4) - 7'd1
                                  : (`SP_DIV_M2_SLOW >> 4) - 7'd1;
    wire         tick2    = (div2_q >= div2_end);
    // timer tick: overflow rate /32 or /16 as bit rate, /16 for oversample
    // overflows are /2 (or /1 doubled) per oversample tick
    wire  [4:0]  ovf_end  = dbl_q ? (`SP_OVF_FAST >> 4) : (`SP_OVF_SLOW >> 4);
    wire         tickt    = i_timer_ovf & (ovf_q >= ovf_end);
    // mode 3 uses the timer like mode 1
    wire         tick     = m0 ? 1'b0 : (mode_bits == 2'b10) ? tick2 : tickt;

    // pin routing: swap takes effect at once on the mux
    wire         rxd_in   = swap ? i_pin_b : i_pin_a;

    // multiprocessor gate: stop bit (mode 1) or ninth bit (modes 2,3)
    // the start bit is shifted in too, so the data byte sits just above it
    wire  [7:0]  rx_byte  = m1 ? rx_sh_q[9:2] : rx_sh_q[8:1];
    wire         rx_tag   = m1 ? rxd_in : rx_sh_q[9];
    wire         rx_ok    = ~rxdn & (~qual | (rx_tag & (rx_byte == addr_q)));
    wire  [3:0]  rx_bits  = m1 ? `SP_BITS_M1 : `SP_BITS_M23;

    // mode 0 shift events
    wire         sclk_rise = m0 & half0 & ~sclk_q;
    wire         sclk_fall = m0 & half0 &  sclk_q;
    wire         m0_busy   = (tx_st_q == serial_port_pkg::TX_SHIFT) |
                             (rx_st_q == serial_port_pkg::RX_SHIFT);

    // async receive centre sample and end of bit
    wire         rx_mid    = tick & (rx_ovs_q == `SP_OVS_MID);
    wire         tx_edge   = tick & (tx_ovs_q == `SP_OVS_LAST);
    wire         rx_fin    = (rx_st_q == serial_port_pkg::RX_SHIFT) & rx_mid &
                             (rx_cnt_q == rx_bits);
    // done flag: 8th rising shift clock, or the edge where the stop bit begins
    wire         tx_fin    = (tx_st_q == serial_port_pkg::TX_SHIFT) & (tx_cnt_q == 4'd1) &
                             (m0 ? sclk_rise : tx_edge);
    wire         rx0_fin   = m0 & (rx_st_q == serial_port_pkg::RX_SHIFT) & sclk_rise &
                             (rx_cnt_q == 4'd7);
    wire         rx_load   = (rx_fin & rx_ok) | rx0_fin;

    // register read mux, unused bits zero
    wire  [7:0]  rd_ctl = ctrl_q;
    wire  [7:0]  rd_aux = aux_q & ~(8'h01 << `SP_AUX1_RO_ZERO);
    wire  [31:0] rd_msc = {16'h0000, addr_q, 7'h00, dbl_q};
    wire  [31:0] rd_sts = {27'h0000000, rxd_in, sclk_q, tx_st_q};
    wire  [31:0] rdata  = hit_dat ? {24'h000000, rxbuf_q} :
                          hit_aux ? {24'h000000, rd_aux} :
                          hit_ctl ? {24'h000000, rd_ctl} :
                          hit_msc ? rd_msc :
                          hit_sts ? rd_sts : 32'h00000000;

    // apb answer registered; pready rises in the access cycle's next edge
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_prdata  <= 32'h00000000;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= acc & ~o_pready;
            o_pslverr <= acc & ~o_pready & ~hit_any;
            o_prdata  <= (acc & ~o_pready & ~i_pwrite) ? rdata : 32'h00000000;
        end
    end

    // the write takes effect on the edge where pready is seen high
    wire         wdone  = wr & o_pready;

    // control register; flag set by hardware beats software clear
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            ctrl_q <= `SP_CTRL_RESET;
        end else begin
            if (wr_ctl & o_pready) begin
                ctrl_q <= wd;
            end
            if (tx_fin) begin
                ctrl_q[`SP_CTRL_TXDONE] <= 1'b1;
            end
            if (rx_load) begin
                ctrl_q[`SP_CTRL_RXDONE] <= 1'b1;
                if (!m0) begin
                    ctrl_q[`SP_CTRL_RXNINTH] <= rx_tag;
                end
            end
        end
    end

    // other software registers
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            aux_q  <= `SP_AUX1_RESET;
            dbl_q  <= 1'b0;
            addr_q <= `SP_ADDR_RESET;
        end else if (wdone & hit_aux) begin
            aux_q  <= wd;
        end else if (wdone & hit_msc) begin
            dbl_q  <= i_pwdata[`SP_MISC_DOUBLE];
            addr_q <= i_pwdata[`SP_MISC_ADDR_HI:`SP_MISC_ADDR_LO];
        end
    end

    // receive register loads only on accepted frames
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rxbuf_q <= `SP_DATA_RESET;
        end else if (rx0_fin) begin
            rxbuf_q <= {rxd_in, rx_sh_q[9:3]};
        end else if (rx_fin & rx_ok) begin
            rxbuf_q <= rx_byte;
        end
    end

    // baud dividers, free running
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            div0_q <= 6'd0;
            div2_q <= 7'd0;
            ovf_q  <= 5'd0;
        end else begin
            div0_q <= half0 ? 6'd0 : div0_q + 6'd1;
            div2_q <= tick2 ? 7'd0 : div2_q + 7'd1;
            if (i_timer_ovf) begin
                ovf_q <= (ovf_q >= ovf_end) ? 5'd0 : ovf_q + 5'd1;
            end
        end
    end

    // mode 0 shift clock, idles high, toggles only while shifting
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            sclk_q <= 1'b1;
        end else if (m0 & m0_busy & half0) begin
            sclk_q <= ~sclk_q;
        end else if (!m0_busy) begin
            sclk_q <= 1'b1;
        end
    end

    // transmitter
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            tx_st_q  <= serial_port_pkg::TX_IDLE;
            tx_sh_q  <= 10'h3ff;
            tx_cnt_q <= 4'd0;
            tx_ovs_q <= 4'd0;
        end else begin
            unique case (tx_st_q)
                serial_port_pkg::TX_IDLE: begin
                    if (wr_dat & o_pready) begin
                        tx_st_q  <= serial_port_pkg::TX_SHIFT;
                        tx_ovs_q <= 4'd0;
                        if (m0) begin
                            tx_sh_q  <= {2'b11, wd};
                            tx_cnt_q <= `SP_BITS_M0;
                        end else if (m1) begin
                            tx_sh_q  <= {1'b1, 1'b1, wd};
                            tx_cnt_q <= `SP_BITS_M1;
                        end else begin
                            tx_sh_q  <= {1'b1, ctrl_q[`SP_CTRL_TXNINTH], wd};
                            tx_cnt_q <= `SP_BITS_M23;
                        end
                    end
                end
                serial_port_pkg::TX_SHIFT: begin
                    if (m0) begin
                        // advance on the rising edge, lsb first
                        if (sclk_rise) begin
                            tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
                            tx_cnt_q <= tx_cnt_q - 4'd1;
                            if (tx_cnt_q == 4'd1) begin
                                tx_st_q <= serial_port_pkg::TX_IDLE;
                            end
                        end
                    end else if (tick) begin
                        tx_ovs_q <= tx_ovs_q + 4'd1;
                        if (tx_edge) begin
                            // pin shows start bit first, then shifts
                            tx_cnt_q <= tx_cnt_q - 4'd1;
                            if (tx_cnt_q == 4'd0) begin
                                tx_st_q <= serial_port_pkg::TX_DONE;
                            end else if (tx_cnt_q != tx_bits_start()) begin
                                tx_sh_q <= {1'b1, tx_sh_q[9:1]};
                            end
                        end
                    end
                end
                serial_port_pkg::TX_DONE: begin
                    // stop bit shown in full; flag was set as it began
                    tx_st_q <= serial_port_pkg::TX_IDLE;
                end
                default: begin
                    tx_st_q <= serial_port_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // first count of an async frame, during which the start bit is shown
    function automatic logic [3:0] tx_bits_start();
        tx_bits_start = m1 ? `SP_BITS_M1 : `SP_BITS_M23;
    endfunction

    // start bit shows while count is at its first value
    wire tx_in_start = ~m0 & (tx_st_q == serial_port_pkg::TX_SHIFT) &
                       (tx_cnt_q == tx_bits_start());
    wire tx_in_stop  = ~m0 & (tx_st_q != serial_port_pkg::TX_IDLE) & (tx_cnt_q == 4'd0);
    wire tx_line     = tx_in_start ? 1'b0 : tx_in_stop ? 1'b1 :
                       (tx_st_q == serial_port_pkg::TX_SHIFT) ? tx_sh_q[0] : 1'b1;

    // receiver
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rx_st_q  <= serial_port_pkg::RX_IDLE;
            rx_sh_q  <= 10'h000;
            rx_cnt_q <= 4'd0;
            rx_ovs_q <= 4'd0;
            rxd_q    <= 1'b1;
        end else begin
            rxd_q <= rxd_in;
            unique case (rx_st_q)
                serial_port_pkg::RX_IDLE: begin
                    rx_cnt_q <= 4'd0;
                    rx_ovs_q <= 4'd0;
                    if (m0) begin
                        // half duplex: start only while tx is idle
                        if (rxen & ~rxdn & (tx_st_q == serial_port_pkg::TX_IDLE)
                            & ~(wr_dat & o_pready)) begin
                            rx_st_q <= serial_port_pkg::RX_SHIFT;
                        end
                    end else if (rxen & rxd_q & ~rxd_in) begin
                        rx_st_q <= serial_port_pkg::RX_SHIFT;
                    end
                end
                serial_port_pkg::RX_SHIFT: begin
                    if (m0) begin
                        // sample on rising shift clock, lsb first
                        if (sclk_rise) begin
                            rx_sh_q  <= {rxd_in, rx_sh_q[9:1]};
                            rx_cnt_q <= rx_cnt_q + 4'd1;
                            if (rx_cnt_q == 4'd7) begin
                                rx_st_q <= serial_port_pkg::RX_END;
                            end
                        end
                    end else if (tick) begin
                        rx_ovs_q <= rx_ovs_q + 4'd1;
                        if (rx_mid) begin
                            if (rx_cnt_q == 4'd0 && rxd_in) begin
                                // false start: glitch, rearm
                                rx_st_q <= serial_port_pkg::RX_IDLE;
                            end else if (rx_fin) begin
                                rx_st_q <= serial_port_pkg::RX_END;
                            end else begin
                                rx_sh_q  <= {rxd_in, rx_sh_q[9:1]};
                                rx_cnt_q <= rx_cnt_q + 4'd1;
                            end
                        end
                    end
                end
                serial_port_pkg::RX_END: begin
                    // back to hunting for a falling edge
                    rx_st_q <= serial_port_pkg::RX_IDLE;
                end
                default: begin
                    rx_st_q <= serial_port_pkg::RX_IDLE;
                end
            endcase
        end
    end

    // pin drivers: mode 0 drives data only while sending
    wire logic_dat     = tx_line;
    wire logic_dat_oen = m0 ? (tx_st_q != serial_port_pkg::TX_SHIFT) : 1'b1;
    wire logic_clk     = m0 ? sclk_q : tx_line;
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            pa_q     <= 1'b1;
            pa_oen_q <= 1'b1;
            pb_q     <= 1'b1;
            pb_oen_q <= 1'b0;
        end else if (swap) begin
            pa_q     <= logic_clk;
            pa_oen_q <= 1'b0;
            pb_q     <= logic_dat;
            pb_oen_q <= logic_dat_oen;
        end else begin
            pa_q     <= logic_dat;
            pa_oen_q <= logic_dat_oen;
            pb_q     <= logic_clk;
            pb_oen_q <= 1'b0;
        end
    end
    assign o_pin_a     = pa_q;
    assign o_pin_a_oen = pa_oen_q;
    assign o_pin_b     = pb_q;
    assign o_pin_b_oen = pb_oen_q;
endmodule
`default_nettype wire

// *** bench/serial_port_four_mode_uart_checker.sv ***
`default_nettype none
module serial_port_four_mode_uart_checker (
    // watched ports
    input wire logic        i_clk,
    input wire logic        i_rstn,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        o_pin_a_oen,
    input wire logic        o_pin_b_oen,
    input wire logic        o_pin_b
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // access phase still waiting for its answer
    wire logic acc = i_psel && i_penable && !o_pready;
    // one of the five decoded words
    wire logic hit = i_paddr inside {12'h09a, 12'h0a2, 12'h0c0, 12'h0c8, 12'h0cc};
    property p_ack; acc |=> o_pready; endproperty
    a_ack: assert property (p_ack) else $error("access not answered");
    property p_pulse; o_pready |=> !o_pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_err; acc && !hit |=> o_pslverr; endproperty
    a_err: assert property (p_err) else $error("unmapped not flagged");
    property p_ok; acc && hit |=> !o_pslverr; endproperty
    a_ok: assert property (p_ok) else $error("mapped flagged");
    property p_idle; !o_pready |-> o_prdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside answer");
    property p_errz; o_pslverr |-> o_pready && o_prdata == 32'h0; endproperty
    a_errz: assert property (p_errz) else $error("bad error answer");
    // the clock or transmit pin is never left floating
    property p_drv; !(o_pin_a_oen && o_pin_b_oen); endproperty
    a_drv: assert property (p_drv) else $error("both pins released");
    // reset must be seen even while reset is low
    property p_rst;
        @(posedge i_clk) disable iff (1'b0)
        !i_rstn |=> !o_pready && o_pin_a_oen && !o_pin_b_oen && o_pin_b;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset pins");
    c_err: cover property (o_pslverr);
    c_clk: cover property ($fell(o_pin_b) && !o_pin_b_oen);
    c_swap: cover property (!o_pin_a_oen);
endmodule
bind serial_port_four_mode_uart serial_port_four_mode_uart_checker chk (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
    .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_pin_a_oen(o_pin_a_oen),
    .o_pin_b_oen(o_pin_b_oen), .o_pin_b(o_pin_b));
`default_nettype wire

// *** bench/serial_peer_model.sv ***
`default_nettype none
module serial_peer_model (
    // system clock and the shift clock line
    input wire logic i_clk,
    input wire logic i_sclk,
    // data line drive, enable high drives
    output logic     o_line,
    output logic     o_en
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] m0_q;  // byte offered as a shift slave
    logic       m0_on; // slave mode armed
    logic       busy;  // async frame in flight
    // line released whenever idle, the pull-up takes over
    assign o_en = m0_on || busy;
    initial begin
        o_line = 1'b1;
        m0_on  = 1'b0;
        busy   = 1'b0;
    end
    // slave to the device clock: next bit after each falling edge
    always @(negedge i_sclk) begin
        if (m0_on) begin
            o_line <= m0_q[0];
            m0_q   <= m0_q >> 1;
        end
    end
    // eleven bit times, lsb first after the start bit
    task automatic send(input logic [10:0] fr, input int bt);
        busy <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            o_line <= fr[i];
            repeat (bt) @(posedge i_clk);
        end
        busy <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** bench/serial_port_four_mode_uart_bench.sv ***
`default_nettype none
module serial_port_four_mode_uart_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rstn, psel, penable, pwrite, ovf, a_o, a_oen, b_o, b_oen;
    logic        pready, pslverr, p_line, p_en, dbl, t9;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  d;
    logic [10:0] f;
    logic [11:0] rst_a [4];  // words read back after reset, last one unmapped
    logic        a_hold;     // data pin as it stood half a cycle before the edge
    int          err_count, num_checks, seed, cyc, bt;
    time         t0;
    // resolved pins, pulled up when nobody drives
    wire logic   line_a = !a_oen ? a_o : (p_en ? p_line : 1'b1);
    wire logic   line_b = !b_oen ? b_o : 1'b1;
    serial_port_four_mode_uart dut (.i_clk(clk), .i_rstn(rstn), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_timer_ovf(ovf),
        .i_pin_a(line_a), .o_pin_a(a_o), .o_pin_a_oen(a_oen),
        .i_pin_b(line_b), .o_pin_b(b_o), .o_pin_b_oen(b_oen));
    serial_peer_model peer (.i_clk(clk), .i_sclk(line_b), .o_line(p_line), .o_en(p_en));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // mode 0 data may change with the clock's rise, so keep what stood before it
    always @(negedge clk) a_hold = line_a;
    // timer overflow every fourth cycle, and the run ceiling
    always @(posedge clk) begin
        cyc <= cyc + 1;
        ovf <= (cyc % 4 == 3);
        if (cyc == 40000) begin
            err_count++;
            finish_test;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // one apb transfer, idle edge first so calls never collide
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= v;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_flag(input int b);
        do apb(1'b0, 12'h0c0, 32'h0); while (rd[b] !== 1'b1);
    endtask
    // sample eleven bits at their centres on the transmit line
    task automatic rd_frame(output logic [10:0] fr);
        @(negedge line_b);
        repeat (bt / 2) @(posedge clk);
        for (int i = 0; i < 11; i++) begin
            fr[i] = line_b;
            repeat (bt) @(posedge clk);
        end
    endtask
    function automatic int bitc(input int m, input logic db);
        if (m == 2) return db ? 32 : 64;
        return (db ? 16 : 32) * 4;
    endfunction
    // mode 1 pads the eleventh slot with idle high
    function automatic logic [10:0] frame(input int m, input logic [7:0] v, input logic n9);
        return (m == 1) ? {2'b11, v, 1'b0} : {1'b1, n9, v, 1'b0};
    endfunction
    initial begin
        {psel, penable, pwrite, paddr, pwdata, ovf} = '0;
        {err_count, num_checks, cyc} = '0;
        seed = 26159;
        rstn = 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        // reset values, then an unmapped word
        rst_a = '{12'h09a, 12'h0a2, 12'h0c0, 12'h010};
        foreach (rst_a[i]) begin
            apb(1'b0, rst_a[i], 32'h0);
            chk(rd, 32'h0);
        end
        // swap only while idle, roles exchange at once
        apb(1'b1, 12'h0a2, 32'h4);
        repeat (2) @(posedge clk);
        chk({a_oen, b_oen}, 2'b01);
        apb(1'b1, 12'h0a2, 32'h0);
        $display("reset and swap test done");
        for (int q = 0; q < 2; q++) begin
            d = 8'($random(seed));
            apb(1'b1, 12'h0c0, {26'h0, q[0], 5'h0});
            apb(1'b1, 12'h09a, {24'h0, d});
            for (int i = 0; i < 8; i++) begin
                @(posedge line_b);
                f[i] = a_hold;
                if (i > 0) chk(32'($time - t0), q ? 10 : 60);
                t0 = $time;
            end
            chk(f[7:0], d);
            wait_flag(1);
        end
        d = 8'($random(seed));
        peer.m0_q  <= d;
        peer.m0_on <= 1'b1;
        apb(1'b1, 12'h0c0, 32'h10);
        wait_flag(0);
        peer.m0_on <= 1'b0;
        apb(1'b0, 12'h09a, 32'h0);
        chk(rd, d);
        $display("shift mode test done");
        for (int m = 1; m < 4; m++) begin
            {dbl, t9, d} = 10'($random(seed));
            bt = bitc(m, dbl);
            apb(1'b1, 12'h0c8, {31'h0, dbl});
            apb(1'b1, 12'h0c0, {24'h0, 2'(m), 2'b01, t9, 3'b000});
            apb(1'b1, 12'h09a, {24'h0, d});
            rd_frame(f);
            chk(f, frame(m, d, t9));
            wait_flag(1);
            // second frame arrives while done is still set
            for (int k = 0; k < 2; k++) begin
                peer.send(frame(m, d ^ 8'(k), t9), bt);
                repeat (bt) @(posedge clk);
                apb(1'b0, 12'h0c0, 32'h0);
                chk(rd[2:0], {(m == 1) | t9, 2'b11});
                apb(1'b0, 12'h09a, 32'h0);
                chk(rd, d);
            end
        end
        // qualifier set, ninth bit low: frame dropped
        apb(1'b1, 12'h0c8, {16'h0, 8'h5a, 7'h0, dbl});
        apb(1'b1, 12'h0c0, 32'hb0);
        peer.send(frame(2, ~d, 1'b0), bitc(2, dbl));
        repeat (bt) @(posedge clk);
        apb(1'b0, 12'h0c0, 32'h0);
        chk(rd, 32'hb0);
        apb(1'b0, 12'h09a, 32'h0);
        chk(rd, d);
        // ninth bit high and the station address matches: frame kept
        peer.send(frame(2, 8'h5a, 1'b1), bitc(2, dbl));
        repeat (bt) @(posedge clk);
        apb(1'b0, 12'h0c0, 32'h0);
        chk(rd, 32'hb5);
        apb(1'b0, 12'h09a, 32'h0);
        chk(rd, 32'h5a);
        $display("async mode test done");
        finish_test;
    end
endmodule
`default_nettype wire
